// ==== hdl/emon_top.sv ====
/*
 * E1 performance monitor: four saturating error counters latched each
 * period, plus transmit and receive channel monitors, behind APB.
 * Assumes framer events and period ticks are one-cycle pulses on
 * i_sys_clk; the period timer and framer live outside.
 */
// Design decision made here: the APB register port.
// Contract
// - Latch counts on selected period boundary
// - Latched counts stand for one period
// - Counters saturate, never wrap
// - 16-bit violation count at 0x00/0x01
// - Mode 0 counts same-polarity consecutive marks
// - HDB3 substitution violations not counted
// - Mode 1 counts same-polarity consecutive violations
// - Violation count always runs, saturates 65535
// - 10-bit CRC count at 0x02/0x03
// - CRC and E-bit hold on frame or CRC multiframe loss
// - E-bit counter counts zero E-bits
// - E-bit count at 0x04/0x05
// - 12-bit alignment count held on sync-lost
// - No alignment counting while searching
// - Alignment count split over 0x02/0x04
// - One transmit and one receive monitor
// - Copy selected transmit octet to monitor
`timescale 1ns/1ps
`default_nettype none

module emon_top
    import emon_pkg::*;
#(
    parameter int VIO_WIDTH = VIO_W,
    parameter int CRC_WIDTH = CRC_W,
    parameter int EBIT_WIDTH = EBIT_W,
    parameter int FAS_WIDTH = FAS_W
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_tick_sec,
    input wire logic i_tick_sub,
    input wire emon_line_s i_line,
    input wire emon_sync_s i_sync,
    input wire emon_frame_ev_s i_frame_ev,
    input wire emon_octet_s i_tx_octet,
    input wire emon_octet_s i_rx_octet
);

    // ==========================================================
    // Control state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CHAN_W-1:0] tx_sel_reg;
    logic [CHAN_W-1:0] rx_sel_reg;
    logic period_sel;
    logic vio_mode;
    logic hdb3_en;

    assign period_sel = ctrl_reg[CTRL_PERIOD_SEL_BIT];
    assign vio_mode = ctrl_reg[CTRL_VIO_MODE_BIT];
    assign hdb3_en = ctrl_reg[CTRL_HDB3_EN_BIT];

    // ==========================================================
    // Period boundary
    logic boundary;

    assign boundary = period_sel ? i_tick_sub : i_tick_sec;

    // ==========================================================
    // Violation detection
    logic mark;
    logic mark_pol;
    logic have_mark_reg;
    logic last_pol_reg;
    logic have_bpv_reg;
    logic last_bpv_pol_reg;
    logic bipolar_violation;
    logic bpv_counted;
    logic cv;
    logic vio_inc;

    // A mark flagged on both rails at once is taken as positive
    assign mark = i_line.mark_pos || i_line.mark_neg;
    assign mark_pol = i_line.mark_pos;

    assign bipolar_violation = mark && have_mark_reg && (mark_pol == last_pol_reg);

    assign bpv_counted = bipolar_violation && !(hdb3_en && i_line.hdb3_sub);

    assign cv = bipolar_violation && have_bpv_reg && (mark_pol == last_bpv_pol_reg);

    // host matches mode to line code
    assign vio_inc = vio_mode ? cv : bpv_counted;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            have_mark_reg <= 1'b0;
            last_pol_reg <= 1'b0;
        end else if (mark) begin
            have_mark_reg <= 1'b1;
            last_pol_reg <= mark_pol;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            have_bpv_reg <= 1'b0;
            last_bpv_pol_reg <= 1'b0;
        end else if (bipolar_violation) begin
            have_bpv_reg <= 1'b1;
            last_bpv_pol_reg <= mark_pol;
        end
    end

    // ==========================================================
    // Accumulating counters
    logic [VIO_WIDTH-1:0] vio_count;
    logic [CRC_WIDTH-1:0] crc_count;
    logic [EBIT_WIDTH-1:0] ebit_count;
    logic [FAS_WIDTH-1:0] fas_count;
    logic crc_hold;
    logic fas_hold;
    logic ebit_inc;

    // hold on frame or CRC multiframe loss; CAS loss ignored
    assign crc_hold = i_sync.loss_frame || i_sync.loss_crc_mf;

    assign fas_hold = i_sync.sync_lost || i_sync.searching;

    assign ebit_inc = i_frame_ev.ebit_valid && !i_frame_ev.ebit_value;

    emon_sat_counter #(
        .W(VIO_WIDTH)
    ) u_vio_cnt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_inc(vio_inc),
        .i_hold(1'b0),
        .i_clear(boundary),
        .o_count(vio_count)
    );

    emon_sat_counter #(
        .W(CRC_WIDTH)
    ) u_crc_cnt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_inc(i_frame_ev.crc_err),
        .i_hold(crc_hold),
        .i_clear(boundary),
        .o_count(crc_count)
    );

    emon_sat_counter #(
        .W(EBIT_WIDTH)
    ) u_ebit_cnt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_inc(ebit_inc),
        .i_hold(crc_hold),
        .i_clear(boundary),
        .o_count(ebit_count)
    );

    emon_sat_counter #(
        .W(FAS_WIDTH)
    ) u_fas_cnt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_inc(i_frame_ev.fas_err),
        .i_hold(fas_hold),
        .i_clear(boundary),
        .o_count(fas_count)
    );

    // ==========================================================
    // Latched counts
    logic [VIO_W-1:0] vio_lat_reg;
    logic [CRC_W-1:0] crc_lat_reg;
    logic [EBIT_W-1:0] ebit_lat_reg;
    logic [FAS_W-1:0] fas_lat_reg;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            vio_lat_reg <= '0;
            crc_lat_reg <= '0;
            ebit_lat_reg <= '0;
            fas_lat_reg <= '0;
        end else if (boundary) begin
            vio_lat_reg <= VIO_W'(vio_count);
            crc_lat_reg <= CRC_W'(crc_count);
            ebit_lat_reg <= EBIT_W'(ebit_count);
            fas_lat_reg <= FAS_W'(fas_count);
        end
    end

    // ==========================================================
    // Channel monitors
    logic [BYTE_W-1:0] tx_mon;
    logic [BYTE_W-1:0] rx_mon;

    emon_chan_monitor u_tx_mon (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_sel(tx_sel_reg),
        .i_octet(i_tx_octet),
        .o_octet(tx_mon)
    );

    emon_chan_monitor u_rx_mon (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_sel(rx_sel_reg),
        .i_octet(i_rx_octet),
        .o_octet(rx_mon)
    );

    // ==========================================================
    // APB access
    logic access;
    logic commit;
    logic [7:0] idx;
    logic aligned;
    logic in_map;
    logic [BYTE_W-1:0] rd_byte;
    logic rd_hit;

    // Fixed one wait state keeps the read mux off the bus path
    assign access = i_psel && i_penable;
    assign commit = access && o_pready;
    assign idx = 8'(i_paddr[ADDR_W-1:2]);
    // Full index compared so high address bits cannot alias a register
    assign in_map = (i_paddr[ADDR_W-1:2] <= (ADDR_W-2)'(REG_RX_MON_IDX));
    assign aligned = (i_paddr[1:0] == 2'b00) && in_map;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= REG_RX_MON_IDX);
    endfunction

    always_comb begin
        rd_byte = '0;
        rd_hit = 1'b1;
        if (idx == REG_VIO_HIGH_IDX) begin
            rd_byte = vio_lat_reg[VIO_W-1 -: BYTE_W];
        end else if (idx == REG_VIO_LOW_IDX) begin
            rd_byte = vio_lat_reg[BYTE_W-1:0];
        end else if (idx == REG_ALIGN_HI_CRC_HI_IDX) begin
            // alignment high half above CRC top bits
            rd_byte = {fas_lat_reg[FAS_W-1 -: FAS_HALF_W],
                       crc_lat_reg[CRC_W-1 -: SPLIT_HI_BITS]};
        end else if (idx == REG_CRC_LOW_IDX) begin
            rd_byte = crc_lat_reg[BYTE_W-1:0];
        end else if (idx == REG_ALIGN_LO_EBIT_HI_IDX) begin
            // E-bit top bits under alignment low half
            rd_byte = {fas_lat_reg[FAS_HALF_W-1:0],
                       ebit_lat_reg[EBIT_W-1 -: SPLIT_HI_BITS]};
        end else if (idx == REG_EBIT_LOW_IDX) begin
            rd_byte = ebit_lat_reg[BYTE_W-1:0];
        end else if (idx == REG_CTRL_IDX) begin
            rd_byte = BYTE_W'(ctrl_reg);
        end else if (idx == REG_TX_SEL_IDX) begin
            rd_byte = BYTE_W'(tx_sel_reg);
        end else if (idx == REG_RX_SEL_IDX) begin
            rd_byte = BYTE_W'(rx_sel_reg);
        end else if (idx == REG_TX_MON_IDX) begin
            rd_byte = tx_mon;
        end else if (idx == REG_RX_MON_IDX) begin
            rd_byte = rx_mon;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= access && !o_pready;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else if (access && !o_pready) begin
            o_prdata <= (!i_pwrite && rd_hit && aligned) ? DATA_W'(rd_byte) : '0;
            o_pslverr <= !(aligned && is_mapped(idx) && rd_hit);
        end else begin
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end
    end

    // Writes to the count and monitor registers are silently ignored
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (commit && i_pwrite && aligned && idx == REG_CTRL_IDX) begin
            ctrl_reg <= i_pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_sel_reg <= CHAN_SEL_RESET;
        end else if (commit && i_pwrite && aligned && idx == REG_TX_SEL_IDX) begin
            tx_sel_reg <= i_pwdata[CHAN_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_sel_reg <= CHAN_SEL_RESET;
        end else if (commit && i_pwrite && aligned && idx == REG_RX_SEL_IDX) begin
            rx_sel_reg <= i_pwdata[CHAN_W-1:0];
        end
    end

endmodule // emon_top

`default_nettype wire

// ==== hdl/emon_pkg.sv ====
/*
 * Shared constants and carriers for the E1 error counter and channel
 * monitor block. Assumes a single system clock and APB register access.
 */
package emon_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] REG_VIO_HIGH_IDX = 8'h00;
    localparam logic [7:0] REG_VIO_LOW_IDX = 8'h01;
    localparam logic [7:0] REG_ALIGN_HI_CRC_HI_IDX = 8'h02;
    localparam logic [7:0] REG_CRC_LOW_IDX = 8'h03;
    localparam logic [7:0] REG_ALIGN_LO_EBIT_HI_IDX = 8'h04;
    localparam logic [7:0] REG_EBIT_LOW_IDX = 8'h05;
    localparam logic [7:0] REG_CTRL_IDX = 8'h06;
    localparam logic [7:0] REG_TX_SEL_IDX = 8'h07;
    localparam logic [7:0] REG_RX_SEL_IDX = 8'h08;
    localparam logic [7:0] REG_TX_MON_IDX = 8'h09;
    localparam logic [7:0] REG_RX_MON_IDX = 8'h0a;

    // ==========================================================
    // Control register fields and reset values
    localparam int CTRL_PERIOD_SEL_BIT = 0;
    localparam int CTRL_VIO_MODE_BIT = 1;
    localparam int CTRL_HDB3_EN_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [4:0] CHAN_SEL_RESET = 5'h00;
    localparam logic [7:0] OCTET_RESET = 8'h00;

    // ==========================================================
    // Counter widths and byte-lane placement
    localparam int VIO_W = 16;
    localparam int CRC_W = 10;
    localparam int EBIT_W = 10;
    localparam int FAS_W = 12;
    localparam int BYTE_W = 8;
    localparam int SPLIT_HI_BITS = 2;
    localparam int FAS_HALF_W = 6;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 5;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic mark_pos;
        logic mark_neg;
        logic hdb3_sub;
    } emon_line_s;

    typedef struct packed {
        logic loss_frame;
        logic loss_crc_mf;
        logic sync_lost;
        logic searching;
    } emon_sync_s;

    typedef struct packed {
        logic crc_err;
        logic ebit_valid;
        logic ebit_value;
        logic fas_err;
    } emon_frame_ev_s;

    typedef struct packed {
        logic valid;
        logic [4:0] slot;
        logic [7:0] data;
    } emon_octet_s;

endpackage

// ==== hdl/emon_sat_counter.sv ====
/*
 * Saturating event counter with hold and period clear.
 * Assumes single-cycle event pulses synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module emon_sat_counter #(
    parameter int W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_inc,
    input wire logic i_hold,
    input wire logic i_clear,
    output logic [W-1:0] o_count
);

    // ==========================================================
    // Counting
    localparam logic [W-1:0] MAX = '1;
    localparam logic [W-1:0] ONE = W'(1);
    logic inc_ok;
    assign inc_ok = i_inc && !i_hold;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count <= '0;
        end else if (i_clear) begin
            // An event on the boundary opens the new period
            o_count <= inc_ok ? ONE : '0;
        end else if (inc_ok && o_count != MAX) begin
            o_count <= o_count + ONE;
        end
    end

endmodule // emon_sat_counter

`default_nettype wire

// ==== hdl/emon_chan_monitor.sv ====
/*
 * Captures the octet of one selected 64 kbit/s channel.
 * Assumes the framer presents each timeslot octet with a valid pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module emon_chan_monitor
    import emon_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [CHAN_W-1:0] i_sel,
    input wire emon_octet_s i_octet,
    output logic [BYTE_W-1:0] o_octet
);

    // ==========================================================
    // Channel match: channel number is timeslot plus one
    logic [CHAN_W-1:0] chan_num;
    assign chan_num = i_octet.slot + CHAN_W'(1);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_octet <= OCTET_RESET;
        end else if (i_octet.valid && chan_num == i_sel) begin
            o_octet <= i_octet.data;
        end
    end

endmodule // emon_chan_monitor

`default_nettype wire

// ==== bench/emon_top_chk.sv ====
/*
 * Port checker for the E1 error monitor: APB answer timing and read lanes.
 * Assumes it is bound to emon_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module emon_top_chk (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_tick_sec,
    input wire logic i_tick_sub
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    // ==========================================================
    // Helper: last answered read of the low violation byte
    logic [31:0] prev_reg;
    logic have_reg;
    wire logic rd_ans = o_pready && !i_pwrite && i_paddr == 12'h004 && !o_pslverr;

    // any tick may move the latch, so forget
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            have_reg <= 1'b0;
            prev_reg <= 32'h0;
        end else if (i_tick_sec || i_tick_sub) begin
            have_reg <= 1'b0;
        end else if (rd_ans) begin
            have_reg <= 1'b1;
            prev_reg <= o_prdata;
        end
    end

    // ==========================================================
    // Assertions
    sequence s_take;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence

    a_answer_one_cycle: assert property (s_take |=> s_answer)
        else $error("answer not a single cycle after take");
    a_no_stray_ready: assert property (o_pready |-> $past(i_psel && i_penable && !o_pready))
        else $error("ready without a request");
    a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    a_byte_lane_only: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_unmapped: assert property (s_take ##0 (i_paddr[11:2] > 10'h00a) |=> o_pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (s_take ##0 (i_paddr[11:2] <= 10'h00a && i_paddr[1:0] == 2'h0)
        |=> !o_pslverr)
        else $error("mapped access refused");
    a_err_with_ready: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error outside answer or with data");
    a_latch_holds: assert property (rd_ans && have_reg |-> o_prdata == prev_reg)
        else $error("latched count moved within a period");
endmodule // emon_top_chk

bind emon_top emon_top_chk chk (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_tick_sec(i_tick_sec),
    .i_tick_sub(i_tick_sub)
);
`default_nettype wire

// ==== bench/emon_framer_model.sv ====
/*
 * Behavioural receive framer, line decoder and period timer.
 * Assumes the bench calls its tasks; all outputs change after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module emon_framer_model
    import emon_pkg::*;
(
    input wire logic i_sys_clk,
    output var emon_line_s o_line,
    output var emon_sync_s o_sync,
    output var emon_frame_ev_s o_frame_ev,
    output var emon_octet_s o_tx_octet,
    output var emon_octet_s o_rx_octet,
    output var logic o_tick_sec,
    output var logic o_tick_sub
);
    initial begin
        o_line = '0;
        o_sync = '0;
        o_frame_ev = '0;
        o_tx_octet = '0;
        o_rx_octet = '0;
        o_tick_sec = 1'b0;
        o_tick_sub = 1'b0;
    end

    // ==========================================================
    // Event drivers: held n cycles gives n input events
    task automatic line_ev(input emon_line_s v, input int n);
        @(posedge i_sys_clk) o_line <= v;
        repeat (n) @(posedge i_sys_clk);
        o_line <= '0;
    endtask

    task automatic frame(input emon_frame_ev_s v, input int n);
        @(posedge i_sys_clk) o_frame_ev <= v;
        repeat (n) @(posedge i_sys_clk);
        o_frame_ev <= '0;
    endtask

    task automatic set_sync(input emon_sync_s v);
        @(posedge i_sys_clk) o_sync <= v;
    endtask

    task automatic tick(input logic sub);
        @(posedge i_sys_clk);
        if (sub) begin
            o_tick_sub <= 1'b1;
        end else begin
            o_tick_sec <= 1'b1;
        end
        @(posedge i_sys_clk);
        o_tick_sub <= 1'b0;
        o_tick_sec <= 1'b0;
    endtask

    // Idle octet data flips so a stale capture cannot pass
    task automatic octet(input logic tx, input logic [4:0] slot, input logic [7:0] d);
        @(posedge i_sys_clk);
        if (tx) begin
            o_tx_octet <= '{1'b1, slot, d};
        end else begin
            o_rx_octet <= '{1'b1, slot, d};
        end
        @(posedge i_sys_clk);
        o_tx_octet <= '{1'b0, ~slot, ~d};
        o_rx_octet <= '{1'b0, ~slot, ~d};
    endtask
endmodule // emon_framer_model
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench for emon_top: APB reads of latched counts.
 * Assumes the framer model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
    import emon_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    emon_line_s line;
    emon_sync_s sync;
    emon_frame_ev_s fev;
    emon_octet_s txo, rxo;
    logic tsec, tsub;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    emon_top uut (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_tick_sec(tsec), .i_tick_sub(tsub),
        .i_line(line), .i_sync(sync), .i_frame_ev(fev), .i_tx_octet(txo), .i_rx_octet(rxo));
    emon_framer_model mdl (.i_sys_clk(clk), .o_line(line), .o_sync(sync), .o_frame_ev(fev),
        .o_tx_octet(txo), .o_rx_octet(rxo), .o_tick_sec(tsec), .o_tick_sub(tsub));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // Run control; longest test is the 65540-cycle saturation
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            mismatches++;
            $display("CHECK FAILED at %0t: timeout", $time);
            conclude();
        end
    end

    // ==========================================================
    // APB master: hold request until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
        output logic [31:0] d, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk) penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] v, input logic ee);
        logic [31:0] d;
        logic e;
        apb(w, idx, v, d, e);
        checks_done++;
        if (e !== ee || d !== (w ? 32'h0 : {24'h0, v})) begin
            mismatches++;
            $display("CHECK FAILED at %0t: index %0h data %h err %b", $time, idx, d, e);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 11; i++) xfer(1'b0, i[9:0], 8'h00, 1'b0);
        xfer(1'b0, 10'h00b, 8'h00, 1'b1);
        xfer(1'b1, 10'h106, 8'h07, 1'b1);
        xfer(1'b0, 10'h006, 8'h00, 1'b0);
        xfer(1'b1, 10'h000, 8'h5a, 1'b0);
        xfer(1'b0, 10'h000, 8'h00, 1'b0);
        done("reset");
        mdl.line_ev(3'h4, 2);
        mdl.line_ev(3'h3, 2);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h001, 8'h00, 1'b0);
        mdl.tick(1'b0);
        xfer(1'b0, 10'h001, 8'h02, 1'b0);
        done("bipolar");
        // HDB3 decoding with short period
        xfer(1'b1, 10'h006, 8'h05, 1'b0);
        mdl.line_ev(3'h3, 1);
        mdl.line_ev(3'h4, 4);
        xfer(1'b0, 10'h001, 8'h02, 1'b0);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h001, 8'h03, 1'b0);
        done("hdb3");
        // Code violation mode
        xfer(1'b1, 10'h006, 8'h03, 1'b0);
        mdl.line_ev(3'h2, 2);
        mdl.line_ev(3'h4, 2);
        mdl.line_ev(3'h4, 2);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h001, 8'h02, 1'b0);
        done("code");
        xfer(1'b1, 10'h006, 8'h01, 1'b0);
        mdl.frame(4'hd, 2);
        mdl.frame(4'h6, 1);
        mdl.frame(4'h8, 1);
        for (int b = 0; b < 4; b++) begin
            mdl.set_sync(emon_sync_s'(4'h8 >> b));
            mdl.frame(4'hd, 1);
        end
        mdl.set_sync(4'h0);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h001, 8'h00, 1'b0);
        xfer(1'b0, 10'h002, 8'h00, 1'b0);
        xfer(1'b0, 10'h003, 8'h05, 1'b0);
        xfer(1'b0, 10'h004, 8'h10, 1'b0);
        xfer(1'b0, 10'h005, 8'h04, 1'b0);
        done("frame");
        mdl.frame(4'h9, 4100);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h002, 8'hff, 1'b0);
        xfer(1'b0, 10'h003, 8'hff, 1'b0);
        xfer(1'b0, 10'h004, 8'hfc, 1'b0);
        xfer(1'b0, 10'h005, 8'h00, 1'b0);
        done("saturate");
        mdl.set_sync(4'h2);
        mdl.line_ev(3'h4, 65540);
        mdl.tick(1'b1);
        xfer(1'b0, 10'h000, 8'hff, 1'b0);
        xfer(1'b0, 10'h001, 8'hff, 1'b0);
        done("violation");
        // Channel number is timeslot plus one
        xfer(1'b1, 10'h007, 8'h06, 1'b0);
        xfer(1'b1, 10'h008, 8'h0f, 1'b0);
        mdl.octet(1'b1, 5'h05, 8'ha5);
        mdl.octet(1'b1, 5'h06, 8'h3c);
        mdl.octet(1'b0, 5'h0e, 8'h5a);
        mdl.octet(1'b0, 5'h0f, 8'hc3);
        xfer(1'b0, 10'h009, 8'ha5, 1'b0);
        xfer(1'b0, 10'h00a, 8'h5a, 1'b0);
        xfer(1'b0, 10'h007, 8'h06, 1'b0);
        done("monitor");
        // Reset in mid-run clears monitors, selects and latches
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        xfer(1'b0, 10'h009, 8'h00, 1'b0);
        xfer(1'b0, 10'h008, 8'h00, 1'b0);
        xfer(1'b0, 10'h000, 8'h00, 1'b0);
        done("reset again");
        conclude();
    end
endmodule // tb
`default_nettype wire
